/* logic/refclk_pkg.sv */
// Notes on behaviour
// - Output-enable bit 15 drives the divided reference onto the pin; clear disables it.
// - Four-bit divisor: code 0 passes base clock, code n divides by two to n (code 0 on system clock halves it instead).
// - Source-select bit 12 picks primary oscillator when set, system clock when clear.
// - Sleep-run bit 13 keeps reference running in Sleep; clear stops it in Sleep.
// - Sleep output needs sleep-run and source-select; primary oscillator off unless keep-alive, or both bits set with primary_osc_mode.
// - Bit 14 and bits 7 to 0 read zero and ignore writes.
// - Low power only by power-save instruction; operand 0 Sleep, operand 1 Idle.
// - Sleep stops system clock source, its on-chip oscillator, and all execution.
// - Fail-safe clock monitor suspended throughout Sleep.
// - Low-power RC kept in Sleep if watchdog on; in Idle if watchdog or monitor.
// - Enabled watchdog cleared just before Sleep entry and on Idle entry.
// - Sleep disables system-clock peripherals; change detect and external-clock ones may run.
// - Regulator-in-sleep bit clear turns regulator off in Sleep, adding wake-up delay.
// - Sleep exits on enabled interrupt, any reset, or watchdog time-out.
// - Wake from Sleep resumes with the clock source active at entry.
// - Idle stops CPU but keeps system clock; peripherals run unless disabled for Idle.
// - Idle exits on enabled interrupt, any reset, or watchdog time-out.
// - Idle wake reapplies CPU clock at once; resume next instruction or service routine.
// - Reference output usable in every oscillator configuration.
// - Interrupt during power-save instruction deferred until entry completes, then wakes.
package refclk_pkg;
    localparam logic [11:0] REF_CTRL_ADDR = 12'h000;
    localparam logic [11:0] RESET_CTRL_ADDR = 12'h004;
    localparam logic [11:0] PS_STATUS_ADDR = 12'h008;
    localparam int OE_BIT = 15;
    localparam int SLEEP_RUN_BIT = 13;
    localparam int SRC_SEL_BIT = 12;
    localparam int DIV_LSB = 8;
    localparam int REG_SLEEP_BIT = 8;
    localparam logic [15:0] REF_CTRL_MASK = 16'hBF00;
    localparam logic [15:0] REF_CTRL_RESET = 16'h0000;
    localparam logic [15:0] RESET_CTRL_RESET = 16'h0100;
    localparam int REG_WAKE_US = 190;
    localparam int CLK_MHZ = 250;
    localparam int REG_WAKE_CYCLES = REG_WAKE_US * CLK_MHZ;
    localparam logic OP_SLEEP = 1'b0;
    localparam logic OP_IDLE = 1'b1;

    typedef enum logic [1:0] {
        PS_RUN = 2'b00,
        PS_SLEEP = 2'b01,
        PS_IDLE = 2'b10,
        PS_WAKE = 2'b11
    } ps_state_e;

    typedef struct packed {
        logic oe;
        logic sleep_run;
        logic src_sel;
        logic [3:0] div;
    } ref_cfg_s;
endpackage

/* logic/refclk_power_save.sv */
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module refclk_power_save #(
    parameter int WAKE_DELAY = refclk_pkg::REG_WAKE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic primary_osc_clk,
    input wire logic primary_osc_keep_alive,
    input wire logic primary_osc_mode,
    input wire logic power_save_instruction,
    input wire logic power_save_operand,
    input wire logic irq_pending,
    input wire logic device_reset_req,
    input wire logic watchdog_timeout,
    input wire logic watchdog_enabled,
    input wire logic fail_safe_clock_monitor_enabled,
    output logic ref_clock_pin,
    output logic system_clock_run,
    output logic primary_osc_run,
    output logic low_power_rc_oscillator_run,
    output logic fail_safe_clock_monitor_active,
    output logic watchdog_clear,
    output logic cpu_clock_run,
    output logic sysclk_periph_run,
    output logic regulator_on,
    output logic [2:0] resume_clock_source,
    input wire logic [2:0] current_clock_source
);
    import refclk_pkg::*;

    logic [15:0] ref_ctrl;
    logic [15:0] reset_ctrl;
    ps_state_e state;
    logic [2:0] saved_source;
    logic [31:0] wake_cnt;
    logic pend_wake;
    logic [2:0] posc_sync;
    logic posc_lvl;
    logic base_prev;
    logic [15:0] div_cnt;
    logic ref_out;
    logic base_rise;
    logic wake_event;
    logic acc;
    logic ref_allowed;
    ref_cfg_s cfg;

    assign cfg = '{oe: ref_ctrl[OE_BIT], sleep_run: ref_ctrl[SLEEP_RUN_BIT],
                   src_sel: ref_ctrl[SRC_SEL_BIT], div: ref_ctrl[DIV_LSB+3:DIV_LSB]};
    assign acc = psel && penable;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    function automatic logic addr_hit(input logic [11:0] a);
        return (a == REF_CTRL_ADDR) || (a == RESET_CTRL_ADDR) || (a == PS_STATUS_ADDR);
    endfunction

    // Register writes; unimplemented bits masked off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_ctrl <= REF_CTRL_RESET;
            reset_ctrl <= RESET_CTRL_RESET;
        end else if (acc && pwrite && addr_hit(paddr)) begin
            if (paddr == REF_CTRL_ADDR) begin
                ref_ctrl <= pwdata[15:0] & REF_CTRL_MASK;
            end
            if (paddr == RESET_CTRL_ADDR) begin
                reset_ctrl <= pwdata[15:0] & RESET_CTRL_RESET;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                REF_CTRL_ADDR: prdata <= {16'h0000, ref_ctrl};
                RESET_CTRL_ADDR: prdata <= {16'h0000, reset_ctrl};
                PS_STATUS_ADDR: prdata <= {27'h0000000, saved_source, state};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // Primary oscillator pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            posc_sync <= 3'b000;
            posc_lvl <= 1'b0;
        end else begin
            posc_sync <= {posc_sync[1:0], primary_osc_clk};
            if (posc_sync[1] == posc_sync[2]) begin
                posc_lvl <= posc_sync[2];
            end
        end
    end

    // Power-save state machine
    assign wake_event = irq_pending || device_reset_req || watchdog_timeout;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PS_RUN;
            saved_source <= 3'b000;
            wake_cnt <= 32'h00000000;
            pend_wake <= 1'b0;
        end else begin
            unique case (state)
                PS_RUN: begin
                    if (power_save_instruction) begin
                        saved_source <= current_clock_source;
                        pend_wake <= irq_pending;
                        state <= (power_save_operand == OP_SLEEP) ? PS_SLEEP : PS_IDLE;
                    end
                end
                PS_SLEEP: begin
                    pend_wake <= 1'b0;
                    if (wake_event || pend_wake) begin
                        wake_cnt <= reset_ctrl[REG_SLEEP_BIT] ? 32'h00000000
                                  : 32'(WAKE_DELAY);
                        state <= PS_WAKE;
                    end
                end
                PS_IDLE: begin
                    pend_wake <= 1'b0;
                    if (wake_event || pend_wake) begin
                        state <= PS_RUN;
                    end
                end
                PS_WAKE: begin
                    if (wake_cnt == 32'h00000000) begin
                        state <= PS_RUN;
                    end else begin
                        wake_cnt <= wake_cnt - 32'h00000001;
                    end
                end
            endcase
        end
    end

    assign resume_clock_source = saved_source;
    assign watchdog_clear = (state == PS_RUN) && power_save_instruction
                            && watchdog_enabled;
    assign system_clock_run = (state != PS_SLEEP) && (state != PS_WAKE);
    assign cpu_clock_run = (state == PS_RUN);
    assign sysclk_periph_run = system_clock_run;
    assign fail_safe_clock_monitor_active = fail_safe_clock_monitor_enabled
                    && system_clock_run;
    assign low_power_rc_oscillator_run = (state == PS_SLEEP || state == PS_WAKE)
                    ? watchdog_enabled
                    : (watchdog_enabled || fail_safe_clock_monitor_enabled);
    assign regulator_on = !(state == PS_SLEEP && !reset_ctrl[REG_SLEEP_BIT]);
    assign primary_osc_run = system_clock_run || primary_osc_keep_alive
                    || (cfg.sleep_run && cfg.src_sel && primary_osc_mode);

    // Reference divider; base is an enable on each rising edge of either source
    assign ref_allowed = cfg.oe && (system_clock_run ||
                         (cfg.sleep_run && cfg.src_sel && primary_osc_run));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_prev <= 1'b0;
        end else begin
            base_prev <= posc_lvl;
        end
    end
    assign base_rise = cfg.src_sel ? (posc_lvl && !base_prev) : 1'b1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 16'h0000;
            ref_out <= 1'b0;
        end else if (!ref_allowed) begin
            div_cnt <= 16'h0000;
            ref_out <= 1'b0;
        end else if (cfg.src_sel && cfg.div == 4'h0) begin
            // Code 0 on the oscillator passes its synchronised level straight out
            div_cnt <= 16'h0000;
            ref_out <= posc_lvl;
        end else if (base_rise) begin
            // Half-period of 2^(n-1) base edges
            // System clock reaches the pin through a flop, so its code 0 gives the toggle rate
            if (div_cnt >= ((16'h0001 << cfg.div) >> 1) - 16'h0001 || cfg.div == 4'h0) begin
                div_cnt <= 16'h0000;
                ref_out <= !ref_out;
            end else begin
                div_cnt <= div_cnt + 16'h0001;
            end
        end
    end
    assign ref_clock_pin = ref_out;

    ref_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ref_allowed |=> !ref_clock_pin) else $error("reference not low when disabled");
    sleep_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PS_RUN && power_save_instruction && power_save_operand == OP_SLEEP)
        |=> state == PS_SLEEP) else $error("sleep not entered");
    idle_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PS_RUN && power_save_instruction && power_save_operand == OP_IDLE)
        |=> state == PS_IDLE) else $error("idle not entered");
    sleep_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == PS_SLEEP |-> !system_clock_run && !cpu_clock_run
        && !fail_safe_clock_monitor_active)
        else $error("clock running in sleep");
    idle_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PS_IDLE && irq_pending) |=> cpu_clock_run) else $error("idle wake");
    sleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PS_SLEEP && watchdog_timeout) |=> state == PS_WAKE)
        else $error("sleep wake");
    watchdog_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PS_RUN && power_save_instruction && watchdog_enabled) |-> watchdog_clear)
        else $error("watchdog not cleared");
    regulator_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PS_SLEEP && reset_ctrl[REG_SLEEP_BIT]) |-> regulator_on)
        else $error("regulator off");
    deferred_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PS_RUN && power_save_instruction && irq_pending && power_save_operand)
        |=> ##1 state == PS_RUN) else $error("deferred interrupt lost");
    unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ref_ctrl & ~REF_CTRL_MASK) == 16'h0000) else $error("unimplemented bit set");
endmodule
`default_nettype wire

/* sim/ref_clock_sink.sv */
`timescale 1ns/10ps
`default_nettype none
module ref_clock_sink (
    input wire logic ref_in,
    output logic [31:0] edges
);
    // External device clocked by the reference pin
    initial edges = 32'h0;
    always @(posedge ref_in) begin
        edges <= edges + 32'h1;
    end
endmodule
`default_nettype wire

/* sim/test_ref_clock_out_and_power_save.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
$display("MISMATCH t=%0t got %0h exp %0h", $time, (g), (e)); end end
module test_ref_clock_out_and_power_save;
    import refclk_pkg::*;
    localparam int WD = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, primary_osc_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, e0, edges;
    logic primary_osc_keep_alive, primary_osc_mode, power_save_instruction, power_save_operand;
    logic irq_pending, device_reset_req, watchdog_timeout, watchdog_enabled;
    logic fail_safe_clock_monitor_enabled, fail_safe_clock_monitor_active;
    logic ref_clock_pin, system_clock_run, primary_osc_run, low_power_rc_oscillator_run;
    logic watchdog_clear, cpu_clock_run, sysclk_periph_run, regulator_on;
    logic [2:0] resume_clock_source, current_clock_source;
    logic [1:0] ocnt;
    int mismatches = 0;
    int tests_run = 0;
    int n;
    refclk_power_save #(.WAKE_DELAY(WD)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .primary_osc_clk, .primary_osc_keep_alive,
        .primary_osc_mode, .power_save_instruction, .power_save_operand, .irq_pending,
        .device_reset_req, .watchdog_timeout, .watchdog_enabled,
        .fail_safe_clock_monitor_enabled, .ref_clock_pin, .system_clock_run, .primary_osc_run,
        .low_power_rc_oscillator_run, .fail_safe_clock_monitor_active, .watchdog_clear,
        .cpu_clock_run, .sysclk_periph_run, .regulator_on, .resume_clock_source,
        .current_clock_source);
    ref_clock_sink sink_u (.ref_in(ref_clock_pin), .edges(edges));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // Primary oscillator at an eighth of pclk
    always @(posedge pclk) begin
        ocnt <= ocnt + 2'h1;
        if (ocnt == 2'h3) begin
            primary_osc_clk <= ~primary_osc_clk;
        end
    end
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic [31:0] v);
        apb(1'b1, REF_CTRL_ADDR, 32'h0);
        apb(1'b1, REF_CTRL_ADDR, v);
    endtask
    task automatic edges_in(input int cyc, input int lo, input int hi);
        repeat (8) @(posedge pclk);
        e0 = edges;
        repeat (cyc) @(posedge pclk);
        `CHK((edges - e0) >= lo && (edges - e0) <= hi, 1'b1)
    endtask
    task automatic enter(input logic op, input logic wake_now);
        @(posedge pclk);
        power_save_instruction <= 1'b1;
        power_save_operand <= op;
        irq_pending <= wake_now;
        #1;
        `CHK(watchdog_clear, watchdog_enabled)
        @(posedge pclk);
        power_save_instruction <= 1'b0;
        irq_pending <= 1'b0;
        #1;
        `CHK(cpu_clock_run, 1'b0)
        `CHK(system_clock_run, op)
        `CHK(sysclk_periph_run, op)
        `CHK(fail_safe_clock_monitor_active, op & fail_safe_clock_monitor_enabled)
        `CHK(low_power_rc_oscillator_run,
             watchdog_enabled | (op & fail_safe_clock_monitor_enabled))
    endtask
    task automatic wake_by(input int src, input int lo, input int hi);
        @(posedge pclk);
        current_clock_source <= 3'h0;
        irq_pending <= (src == 0);
        device_reset_req <= (src == 1);
        watchdog_timeout <= (src == 2);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (cpu_clock_run !== 1'b1 && n < 200);
        `CHK(n >= lo && n <= hi, 1'b1)
        @(posedge pclk);
        {irq_pending, device_reset_req, watchdog_timeout} <= 3'b000;
    endtask
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ocnt, primary_osc_clk} = '0;
        {primary_osc_keep_alive, power_save_instruction, power_save_operand} = '0;
        {irq_pending, device_reset_req, watchdog_timeout, fail_safe_clock_monitor_enabled} = '0;
        primary_osc_mode = 1'b1;
        watchdog_enabled = 1'b1;
        current_clock_source = 3'h2;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, REF_CTRL_ADDR, 32'h0);
        `CHK(rd, {16'h0000, REF_CTRL_RESET})
        apb(1'b0, RESET_CTRL_ADDR, 32'h0);
        `CHK(rd, {16'h0000, RESET_CTRL_RESET})
        apb(1'b1, REF_CTRL_ADDR, 32'hFFFF_FFFF);
        apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
        apb(1'b0, REF_CTRL_ADDR, 32'h0);
        `CHK(rd, {16'h0000, REF_CTRL_MASK})
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, REF_CTRL_ADDR, 32'h0);
        edges_in(64, 0, 0);
        `CHK(ref_clock_pin, 1'b0)
        $display("test registers done");
        for (int d = 0; d < 4; d++) begin
            n = (d == 0) ? 64 : 128 >> d;
            cfg(32'h8000 | (d << 8));
            edges_in(128, n - 1, n + 1);
        end
        cfg(32'h9100);
        edges_in(256, 15, 17);
        cfg(32'h9000);
        edges_in(256, 31, 33);
        cfg(32'hB100);
        enter(1'b0, 1'b0);
        `CHK(primary_osc_run, 1'b1)
        edges_in(256, 15, 17);
        wake_by(0, 2, 2);
        cfg(32'h9100);
        enter(1'b0, 1'b0);
        `CHK(primary_osc_run, 1'b0)
        edges_in(64, 0, 0);
        primary_osc_keep_alive <= 1'b1;
        @(posedge pclk);
        #1;
        `CHK(primary_osc_run, 1'b1)
        `CHK(ref_clock_pin, 1'b0)
        @(posedge pclk);
        primary_osc_keep_alive <= 1'b0;
        wake_by(1, 2, 2);
        $display("test reference done");
        for (int m = 0; m < 2; m++) begin
            for (int s = 0; s < 3; s++) begin
                @(posedge pclk);
                watchdog_enabled <= s[0];
                fail_safe_clock_monitor_enabled <= s[1];
                current_clock_source <= 3'(s + 3);
                enter(m[0], 1'b0);
                `CHK(regulator_on, 1'b1)
                wake_by(s, 2 - m, 2 - m);
                `CHK(resume_clock_source, 3'(s + 3))
            end
        end
        apb(1'b0, PS_STATUS_ADDR, 32'h0);
        `CHK(rd, 32'h0000_0014)
        apb(1'b1, RESET_CTRL_ADDR, 32'h0);
        enter(1'b0, 1'b0);
        `CHK(regulator_on, 1'b0)
        wake_by(0, WD, WD + 3);
        apb(1'b1, RESET_CTRL_ADDR, 32'h100);
        enter(1'b0, 1'b1);
        wake_by(3, 1, 1);
        enter(1'b1, 1'b1);
        wake_by(3, 1, 1);
        $display("test power save done");
        final_report;
    end
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
endmodule
`default_nettype wire
